// *** rtl/fas_sequencer.sv ***
// Fault auto-reset sequencer with register port, timers and interrupt
////////////////////////////////////////////////////////////////////////////////
module fas_sequencer
    import fas_pkg::*;
#(
    parameter int TICK_CYCLES = fas_pkg::FAS_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Fault events from the drive, one bit per fault kind
    input wire logic [fas_pkg::FAS_NUM_FAULTS-1:0] fault_event,
    // Drive reached run after a restart
    input wire logic run_reached,
    // Manual reset sources
    input wire logic stop_key,
    input wire logic fault_display_active,
    input wire logic di_fault_reset,
    // Serial link supervision
    input wire logic serial_ctrl_active,
    input wire logic telegram_valid,
    // Power-up DC bus check
    input wire logic powerup_check,
    input wire logic dc_bus_abnormal,
    // Drive commands and indications
    output logic drive_stop,
    output logic restart_req,
    output logic restart_flying,
    output logic locked_out,
    output logic manual_reset_needed,
    output logic net_warning,
    output logic bus_warning,
    output logic not_ready,
    output logic irq
);
    import fas_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [FAS_CTRL_W-1:0] ctrl_q;
    logic [3:0] limit_q;
    logic [15:0] delay_q;
    logic [11:0] interval_q;
    logic [15:0] policy_q;
    logic [FAS_IRQ_W-1:0] irq_stat_q;
    logic [FAS_IRQ_W-1:0] irq_stat_d;
    logic [FAS_IRQ_W-1:0] irq_mask_q;
    logic [15:0] rdata_q;

    fas_state_t st_q;
    fas_state_t st_d;
    logic [3:0] count_q;
    logic [3:0] count_d;
    logic net_lost_q;

    logic drive_stop_q;
    logic restart_req_q;
    logic restart_flying_q;
    logic locked_out_q;
    logic manual_q;
    logic net_warning_q;
    logic bus_warning_q;
    logic not_ready_q;
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode
    wire wr_ctrl = reg_wr && (reg_addr == FAS_ADDR_CTRL);
    wire wr_limit = reg_wr && (reg_addr == FAS_ADDR_LIMIT);
    wire wr_delay = reg_wr && (reg_addr == FAS_ADDR_DELAY);
    wire wr_interval = reg_wr && (reg_addr == FAS_ADDR_INTERVAL);
    wire wr_policy = reg_wr && (reg_addr == FAS_ADDR_POLICY);
    wire wr_irq_stat = reg_wr && (reg_addr == FAS_ADDR_IRQ_STAT);
    wire wr_irq_mask = reg_wr && (reg_addr == FAS_ADDR_IRQ_MASK);

    // Written settings clamped into their legal ranges
    wire [15:0] limit_clamped = fas_clamp(reg_wdata, 16'h0000, FAS_LIMIT_MAX);
    wire [15:0] delay_clamped = fas_clamp(reg_wdata, FAS_DELAY_MIN, FAS_DELAY_MAX);
    wire [15:0] interval_clamped = fas_clamp(reg_wdata, 16'h0000, FAS_INTERVAL_MAX);

    // Field views
    wire [FAS_NUM_FAULTS-1:0] ar_enable = ctrl_q[FAS_NUM_FAULTS-1:0];
    wire flying_sel = ctrl_q[FAS_CTRL_FLYING_BIT];
    wire two_wire = ctrl_q[FAS_CTRL_TWO_WIRE_BIT];
    wire [1:0] net_action = policy_q[FAS_POL_NET_LSB +: 2];
    wire [1:0] bus_action = policy_q[FAS_POL_BUS_LSB +: 2];
    wire [FAS_POL_COMM_W-1:0] comm_timeout = policy_q[FAS_POL_COMM_LSB +: FAS_POL_COMM_W];

    // Status word: lockout flag, state code, attempt count
    wire [15:0] status_word = {8'h00, locked_out_q, st_q, count_q};

    // Read selection; unmapped addresses read zero
    wire [15:0] rd_mux =
        (reg_addr == FAS_ADDR_CTRL) ? 16'(ctrl_q) :
        (reg_addr == FAS_ADDR_LIMIT) ? 16'(limit_q) :
        (reg_addr == FAS_ADDR_DELAY) ? delay_q :
        (reg_addr == FAS_ADDR_INTERVAL) ? 16'(interval_q) :
        (reg_addr == FAS_ADDR_POLICY) ? policy_q :
        (reg_addr == FAS_ADDR_STATUS) ? status_word :
        (reg_addr == FAS_ADDR_IRQ_STAT) ? 16'(irq_stat_q) :
        (reg_addr == FAS_ADDR_IRQ_MASK) ? 16'(irq_mask_q) : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Timers on the 100 ms system tick
    logic tick;
    logic delay_busy;
    logic delay_done;
    logic interval_busy;
    logic interval_done;
    logic comm_done;

    fas_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .reset(reset),
        .tick(tick)
    );

    // Delay timer loads when the wait begins
    wire delay_load = (st_d == ST_WAIT) && (st_q != ST_WAIT);

    fas_timer #(
        .W(16)
    ) u_delay (
        .core_clk(core_clk),
        .reset(reset),
        .tick(tick),
        .load(delay_load),
        .load_val(delay_q),
        .busy(delay_busy),
        .expired(delay_done)
    );

    // Interval starts with the first auto-reset fault of a window
    wire auto_taken;
    wire interval_load = auto_taken && !interval_busy;
    wire [15:0] interval_tenths = 16'(interval_q * FAS_TENTHS_PER_SEC);

    fas_timer #(
        .W(16)
    ) u_interval (
        .core_clk(core_clk),
        .reset(reset),
        .tick(tick),
        .load(interval_load),
        .load_val(interval_tenths),
        .busy(interval_busy),
        .expired(interval_done)
    );

    // Telegram watchdog restarts on every valid telegram
    wire comm_load = telegram_valid || !serial_ctrl_active || comm_done;

    fas_timer #(
        .W(FAS_POL_COMM_W)
    ) u_comm (
        .core_clk(core_clk),
        .reset(reset),
        .tick(tick),
        .load(comm_load),
        .load_val(comm_timeout),
        .busy(),
        .expired(comm_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Fault classification
    wire fault_any = |fault_event;
    // Every raised fault must have its own enable for auto-reset
    wire all_eligible = fault_any && ((fault_event & ~ar_enable) == '0);
    wire net_timed_out = comm_done && serial_ctrl_active && !telegram_valid;
    wire net_fault = net_timed_out && (net_action == FAS_ACT_FAULT);
    wire bus_bad = powerup_check && dc_bus_abnormal;
    wire bus_fault = bus_bad && (bus_action == FAS_ACT_FAULT);
    wire hard_fault = net_fault || bus_fault || (fault_any && !all_eligible);
    wire can_auto = all_eligible && two_wire && (count_q < limit_q);
    wire over_limit = all_eligible && two_wire && (count_q >= limit_q);
    wire manual_reset = (stop_key && fault_display_active) || di_fault_reset;
    wire fault_seen = (st_q == ST_RUN) || (st_q == ST_RESTART);

    assign auto_taken = fault_seen && !hard_fault && can_auto;

    ////////////////////////////////////////////////////////////////////////////
    // Recovery state machine
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_RUN, ST_RESTART: begin
                if (hard_fault) begin
                    st_d = ST_MANUAL;
                end else if (can_auto) begin
                    st_d = ST_WAIT;
                end else if (over_limit) begin
                    st_d = ST_LOCKED;
                end else if (fault_any) begin
                    st_d = ST_MANUAL;
                end else if ((st_q == ST_RESTART) && run_reached) begin
                    st_d = ST_RUN;
                end
            end
            ST_WAIT: begin
                if (hard_fault) begin
                    st_d = ST_MANUAL;
                end else if (manual_reset) begin
                    st_d = ST_RUN;
                end else if (delay_done) begin
                    st_d = ST_RESTART;
                end
            end
            ST_LOCKED, ST_MANUAL: begin
                if (manual_reset && !hard_fault) begin
                    st_d = ST_RUN;
                end
            end
            default: begin
                st_d = ST_MANUAL;
            end
        endcase
    end

    // Attempt counter: cleared by interval expiry or manual reset, bumped per restart
    wire attempt = (st_q == ST_WAIT) && (st_d == ST_RESTART);
    wire count_clr = interval_done || (manual_reset && (st_d == ST_RUN) && (st_q != ST_RUN));
    wire [3:0] count_base = count_clr ? 4'h0 : count_q;
    assign count_d = (attempt && count_base != 4'hf) ? count_base + 4'h1 : count_base;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events; a set in the same cycle as a clear wins
    wire [FAS_IRQ_W-1:0] irq_set;
    assign irq_set[FAS_IRQ_FAULT] = fault_seen && (st_d != st_q) && (st_d != ST_RUN);
    assign irq_set[FAS_IRQ_RESTART] = attempt;
    assign irq_set[FAS_IRQ_LOCKOUT] = (st_d == ST_LOCKED) && (st_q != ST_LOCKED);
    assign irq_set[FAS_IRQ_NET] = net_timed_out && (net_action != FAS_ACT_DISABLED);
    assign irq_set[FAS_IRQ_BUS] = bus_bad;
    wire [FAS_IRQ_W-1:0] irq_clr = wr_irq_stat ? reg_wdata[FAS_IRQ_W-1:0] : '0;
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

    ////////////////////////////////////////////////////////////////////////////
    // Setting registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q <= FAS_CTRL_RESET;
            limit_q <= FAS_LIMIT_RESET;
            delay_q <= FAS_DELAY_RESET;
            interval_q <= FAS_INTERVAL_RESET;
            policy_q <= FAS_POLICY_RESET;
            irq_mask_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata[FAS_CTRL_W-1:0];
            if (wr_limit) limit_q <= limit_clamped[3:0];
            if (wr_delay) delay_q <= delay_clamped;
            if (wr_interval) interval_q <= interval_clamped[11:0];
            if (wr_policy) policy_q <= reg_wdata;
            if (wr_irq_mask) irq_mask_q <= reg_wdata[FAS_IRQ_W-1:0];
        end
    end

    // Read data stands the cycle after the strobe only
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // Sequencer state, counter, link loss and interrupt status
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= ST_RUN;
            count_q <= 4'h0;
            net_lost_q <= 1'b0;
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            count_q <= count_d;
            net_lost_q <= serial_ctrl_active && !telegram_valid && (net_lost_q || net_timed_out);
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive command outputs
    wire bus_hold = bus_bad && (bus_action != FAS_ACT_FAULT);
    wire stopped = (st_d == ST_WAIT) || (st_d == ST_LOCKED) || (st_d == ST_MANUAL);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            drive_stop_q <= 1'b0;
            restart_req_q <= 1'b0;
            restart_flying_q <= 1'b0;
            locked_out_q <= 1'b0;
            manual_q <= 1'b0;
            net_warning_q <= 1'b0;
            bus_warning_q <= 1'b0;
            not_ready_q <= 1'b0;
        end else begin
            drive_stop_q <= stopped || bus_hold;
            restart_req_q <= attempt;
            restart_flying_q <= flying_sel;
            locked_out_q <= (st_d == ST_LOCKED);
            manual_q <= (st_d == ST_LOCKED) || (st_d == ST_MANUAL);
            net_warning_q <= (net_lost_q || net_timed_out) && serial_ctrl_active && !telegram_valid
                && (net_action == FAS_ACT_WARNING);
            bus_warning_q <= bus_bad && (bus_action == FAS_ACT_WARNING);
            not_ready_q <= bus_bad && (bus_action == FAS_ACT_DISABLED);
        end
    end

    assign reg_rdata = rdata_q;
    assign drive_stop = drive_stop_q;
    assign restart_req = restart_req_q;
    assign restart_flying = restart_flying_q;
    assign locked_out = locked_out_q;
    assign manual_reset_needed = manual_q;
    assign net_warning = net_warning_q;
    assign bus_warning = bus_warning_q;
    assign not_ready = not_ready_q;
    assign irq = irq_q;
endmodule : fas_sequencer

// *** rtl/fas_tick_gen.sv ***
// Divider producing the one-cycle system tick
module fas_tick_gen #(
    parameter int CYCLES = 20000000
) (
    input wire logic core_clk,
    input wire logic reset,
    output logic tick
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic tick_q;
    wire wrap = (cnt_q == LAST);

    // Free running count, one pulse per period
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            tick_q <= wrap;
        end
    end

    assign tick = tick_q;
endmodule : fas_tick_gen

// *** rtl/fas_timer.sv ***
// Down counter in system ticks with a one-cycle expiry pulse
module fas_timer #(
    parameter int W = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic busy,
    output logic expired
);
    logic [W-1:0] cnt_q;
    logic exp_q;
    wire last = tick && (cnt_q == W'(1));

    // Load restarts the count; a zero load expires at once
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else if (load) begin
            cnt_q <= load_val;
            exp_q <= (load_val == '0);
        end else begin
            cnt_q <= (tick && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
            exp_q <= last;
        end
    end

    assign busy = (cnt_q != '0);
    assign expired = exp_q;
endmodule : fas_timer

// *** shared/fas_pkg.sv ***
// Constants, field layouts and types for the fault auto-reset sequencer
package fas_pkg;

    // Register word addresses
    localparam logic [3:0] FAS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] FAS_ADDR_LIMIT = 4'h1;
    localparam logic [3:0] FAS_ADDR_DELAY = 4'h2;
    localparam logic [3:0] FAS_ADDR_INTERVAL = 4'h3;
    localparam logic [3:0] FAS_ADDR_POLICY = 4'h4;
    localparam logic [3:0] FAS_ADDR_STATUS = 4'h5;
    localparam logic [3:0] FAS_ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] FAS_ADDR_IRQ_MASK = 4'h7;

    // Fault vector positions, also the enable bit positions of CTRL
    localparam int FAS_FLT_OV = 0;
    localparam int FAS_FLT_OC = 1;
    localparam int FAS_FLT_OT = 2;
    localparam int FAS_FLT_BRAKE = 3;
    localparam int FAS_FLT_REF_LOSS = 4;
    localparam int FAS_FLT_EXT = 5;
    localparam int FAS_FLT_MOTOR_OVLD = 6;
    localparam int FAS_NUM_FAULTS = 7;

    // CTRL layout
    localparam int FAS_CTRL_FLYING_BIT = 7;
    localparam int FAS_CTRL_TWO_WIRE_BIT = 8;
    localparam int FAS_CTRL_W = 9;
    localparam logic [FAS_CTRL_W-1:0] FAS_CTRL_RESET = 9'h000;

    // Lockout limit, auto reset delay (0.1 s units), lockout interval (s)
    localparam logic [15:0] FAS_LIMIT_MAX = 16'h000a;
    localparam logic [3:0] FAS_LIMIT_RESET = 4'h0;
    localparam logic [15:0] FAS_DELAY_MIN = 16'h0001;
    localparam logic [15:0] FAS_DELAY_MAX = 16'h8ca0;
    localparam logic [15:0] FAS_DELAY_RESET = 16'h000a;
    localparam logic [15:0] FAS_INTERVAL_MAX = 16'h0e10;
    localparam logic [11:0] FAS_INTERVAL_RESET = 12'h000;
    localparam logic [15:0] FAS_TENTHS_PER_SEC = 16'h000a;

    // POLICY layout: net action, bus action, comm timeout in 0.1 s units
    localparam int FAS_POL_NET_LSB = 0;
    localparam int FAS_POL_BUS_LSB = 2;
    localparam int FAS_POL_COMM_LSB = 4;
    localparam int FAS_POL_COMM_W = 12;
    localparam logic [15:0] FAS_POLICY_RESET = 16'h00a8;

    // Action encodings shared by the net timeout and bus voltage policies
    localparam logic [1:0] FAS_ACT_DISABLED = 2'h0;
    localparam logic [1:0] FAS_ACT_WARNING = 2'h1;
    localparam logic [1:0] FAS_ACT_FAULT = 2'h2;

    // Interrupt status bits
    localparam int FAS_IRQ_FAULT = 0;
    localparam int FAS_IRQ_RESTART = 1;
    localparam int FAS_IRQ_LOCKOUT = 2;
    localparam int FAS_IRQ_NET = 3;
    localparam int FAS_IRQ_BUS = 4;
    localparam int FAS_IRQ_W = 5;

    // System tick of 100 ms at the 200 MHz core clock
    localparam int FAS_TICK_TIME_MS = 100;
    localparam int FAS_CLK_FREQ_MHZ = 200;
    localparam int FAS_TICK_CYCLES = FAS_TICK_TIME_MS * 1000 * FAS_CLK_FREQ_MHZ;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT,
        ST_RESTART,
        ST_LOCKED,
        ST_MANUAL
    } fas_state_t;

    // Clamp a written value into its legal range
    function automatic logic [15:0] fas_clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        fas_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : fas_clamp

endpackage : fas_pkg

// *** verification/fas_monitor.sv ***
// Port-level checker for the fault auto-reset sequencer
module fas_monitor
    import fas_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [fas_pkg::FAS_NUM_FAULTS-1:0] fault_event,
    input wire logic stop_key,
    input wire logic fault_display_active,
    input wire logic di_fault_reset,
    input wire logic serial_ctrl_active,
    input wire logic powerup_check,
    input wire logic drive_stop,
    input wire logic restart_req,
    input wire logic locked_out,
    input wire logic manual_reset_needed,
    input wire logic not_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Stop, restart and lockout relations
    property p_fault_stops; (fault_event != '0 && !drive_stop) |=> drive_stop; endproperty
    a_fault_stops: assert property (p_fault_stops) else $error("no stop after fault");
    property p_req_pulse; restart_req |=> !restart_req; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("long restart pulse");
    property p_req_after_wait; (restart_req && !powerup_check) |-> $past(drive_stop) && !drive_stop; endproperty
    a_req_after_wait: assert property (p_req_after_wait) else $error("restart without stop");
    property p_lock_manual; locked_out |-> manual_reset_needed && drive_stop; endproperty
    a_lock_manual: assert property (p_lock_manual) else $error("lockout not manual");
    property p_locked_no_req; locked_out |=> !restart_req; endproperty
    a_locked_no_req: assert property (p_locked_no_req) else $error("restart in lockout");
    property p_locked_hold; (locked_out && !di_fault_reset && !stop_key) |=> locked_out; endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("lockout left");
    // Manual reset sources and not-ready stop
    property p_manual_clear;
        (manual_reset_needed && di_fault_reset && !serial_ctrl_active && !powerup_check) |=> !manual_reset_needed;
    endproperty
    a_manual_clear: assert property (p_manual_clear) else $error("input reset ignored");
    property p_key_display;
        (manual_reset_needed && stop_key && !fault_display_active && !di_fault_reset) |=> manual_reset_needed;
    endproperty
    a_key_display: assert property (p_key_display) else $error("key reset unshown");
    property p_not_ready; not_ready |-> drive_stop; endproperty
    a_not_ready: assert property (p_not_ready) else $error("not ready running");
    // Main scenarios reached
    c_restart: cover property (restart_req);
    c_lock: cover property ($rose(locked_out));
    c_not_ready: cover property (not_ready);
endmodule : fas_monitor

bind fas_sequencer fas_monitor mon (.core_clk, .reset, .fault_event, .stop_key, .fault_display_active,
    .di_fault_reset, .serial_ctrl_active, .powerup_check, .drive_stop, .restart_req, .locked_out,
    .manual_reset_needed, .not_ready);

// *** verification/fas_partner.sv ***
// Keypad, digital input and serial master model
module fas_partner (
    input wire logic core_clk,
    input wire logic key_cmd,
    input wire logic hide_cmd,
    input wire logic di_cmd,
    input wire logic link_cmd,
    input wire logic tel_cmd,
    input wire logic manual_reset_needed,
    output logic stop_key,
    output logic fault_display_active,
    output logic di_fault_reset,
    output logic serial_ctrl_active,
    output logic telegram_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // Fault shown unless paged away
    assign fault_display_active = manual_reset_needed && !hide_cmd;
    // Lines follow the commands a cycle later
    always_ff @(posedge core_clk) begin
        stop_key <= key_cmd;
        di_fault_reset <= di_cmd;
        serial_ctrl_active <= link_cmd;
        telegram_valid <= tel_cmd;
    end
endmodule : fas_partner

// *** verification/tb.sv ***
// Self-checking bench for the fault auto-reset sequencer
module tb
    import fas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, run_reached = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [FAS_NUM_FAULTS-1:0] fault_event = '0;
    logic key_cmd = 1'b0, hide_cmd = 1'b0, di_cmd = 1'b0, link_cmd = 1'b0, tel_cmd = 1'b0;
    logic powerup_check = 1'b0, dc_bus_abnormal = 1'b0;
    logic stop_key, fault_display_active, di_fault_reset, serial_ctrl_active, telegram_valid;
    logic drive_stop, restart_req, restart_flying, locked_out, manual_reset_needed;
    logic net_warning, bus_warning, not_ready, irq;
    int failures = 0, tests_run = 0;

    fas_sequencer #(.TICK_CYCLES(4)) uut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .fault_event, .run_reached, .stop_key, .fault_display_active, .di_fault_reset, .serial_ctrl_active,
        .telegram_valid, .powerup_check, .dc_bus_abnormal, .drive_stop, .restart_req, .restart_flying,
        .locked_out, .manual_reset_needed, .net_warning, .bus_warning, .not_ready, .irq);
    fas_partner far (.core_clk, .key_cmd, .hide_cmd, .di_cmd, .link_cmd, .tel_cmd, .manual_reset_needed,
        .stop_key, .fault_display_active, .di_fault_reset, .serial_ctrl_active, .telegram_valid);

    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task test_done();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data checked the cycle after the strobe
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task fault(input int i);
        @(posedge core_clk);
        fault_event <= 7'h01 << i;
        @(posedge core_clk);
        fault_event <= '0;
        cyc(2);
    endtask : fault

    // Manual reset by key or input
    task manual(input bit key);
        @(posedge core_clk);
        key_cmd <= key;
        di_cmd <= !key;
        @(posedge core_clk);
        key_cmd <= 1'b0;
        di_cmd <= 1'b0;
        cyc(3);
    endtask : manual

    task wait_req();
        for (int n = 0; restart_req !== 1'b1; n++) begin
            cyc(1);
            if (n == 300) begin
                failures++;
                test_done();
            end
        end
    endtask : wait_req

    task run_ok();
        @(posedge core_clk);
        run_reached <= 1'b1;
        @(posedge core_clk);
        run_reached <= 1'b0;
    endtask : run_ok

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #400us;
        failures++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        rd(FAS_ADDR_CTRL, 16'h0000);
        rd(FAS_ADDR_DELAY, 16'h000a);
        rd(FAS_ADDR_POLICY, 16'h00a8);
        rd(4'h8, 16'h0000);
        // Interval expiry clears the count
        wr(FAS_ADDR_LIMIT, 16'h0001);
        wr(FAS_ADDR_INTERVAL, 16'h0002);
        wr(FAS_ADDR_CTRL, 16'h0101);
        fault(0);
        chk(drive_stop, 1);
        wait_req();
        rd(FAS_ADDR_STATUS, 16'h0021);
        run_ok();
        cyc(60);
        rd(FAS_ADDR_STATUS, 16'h0000);
        fault(0);
        chk(manual_reset_needed, 0);
        manual(0);
        // Range limits
        wr(FAS_ADDR_LIMIT, 16'h000f);
        rd(FAS_ADDR_LIMIT, 16'h000a);
        wr(FAS_ADDR_DELAY, 16'h0000);
        rd(FAS_ADDR_DELAY, 16'h0001);
        wr(FAS_ADDR_DELAY, 16'h000a);
        wr(FAS_ADDR_INTERVAL, 16'hffff);
        rd(FAS_ADDR_INTERVAL, 16'h0e10);
        // Each fault needs its own enable
        for (int i = 0; i < FAS_NUM_FAULTS; i++) begin
            wr(FAS_ADDR_CTRL, 16'h0100);
            fault(i);
            chk(manual_reset_needed, 1);
            manual(0);
            wr(FAS_ADDR_CTRL, 16'h0100 | (16'h0001 << i));
            fault(i);
            chk({manual_reset_needed, drive_stop}, 2'b01);
            manual(0);
            chk(drive_stop, 0);
        end
        // Flying restarts, then lockout
        wr(FAS_ADDR_LIMIT, 16'h0002);
        wr(FAS_ADDR_CTRL, 16'h0181);
        fault(0);
        wait_req();
        chk({restart_flying, drive_stop}, 2'b10);
        rd(FAS_ADDR_STATUS, 16'h0021);
        fault(0);
        wait_req();
        rd(FAS_ADDR_STATUS, 16'h0022);
        fault(0);
        chk(locked_out, 1);
        rd(FAS_ADDR_STATUS, 16'h00b2);
        @(posedge core_clk);
        hide_cmd <= 1'b1;
        manual(1);
        chk(manual_reset_needed, 1);
        hide_cmd <= 1'b0;
        manual(1);
        rd(FAS_ADDR_STATUS, 16'h0000);
        // Ramp restart; none without two-wire
        wr(FAS_ADDR_CTRL, 16'h0101);
        fault(0);
        wait_req();
        chk(restart_flying, 0);
        run_ok();
        wr(FAS_ADDR_CTRL, 16'h0001);
        fault(0);
        cyc(60);
        chk({locked_out, manual_reset_needed, drive_stop}, 3'b011);
        manual(0);
        // Telegram timeout actions
        for (logic [15:0] a = 0; a < 3; a++) begin
            wr(FAS_ADDR_POLICY, 16'h0018 | a);
            @(posedge core_clk);
            link_cmd <= 1'b1;
            cyc(40);
            chk({net_warning, manual_reset_needed, drive_stop}, {a == 1, a == 2, a == 2});
            @(posedge core_clk);
            tel_cmd <= 1'b1;
            link_cmd <= 1'b0;
            @(posedge core_clk);
            tel_cmd <= 1'b0;
            cyc(3);
            manual(0);
            chk({net_warning, manual_reset_needed}, 2'b00);
        end
        // Bus voltage actions at power-up
        for (logic [15:0] a = 0; a < 3; a++) begin
            wr(FAS_ADDR_POLICY, 16'h0010 | (a << 2));
            @(posedge core_clk);
            powerup_check <= 1'b1;
            dc_bus_abnormal <= 1'b1;
            cyc(4);
            chk({not_ready, bus_warning, manual_reset_needed, drive_stop}, {a == 0, a == 1, a == 2, 1'b1});
            @(posedge core_clk);
            powerup_check <= 1'b0;
            dc_bus_abnormal <= 1'b0;
            cyc(3);
            manual(0);
            chk(drive_stop, 0);
        end
        // Fault interrupt, mask and clear
        wr(FAS_ADDR_IRQ_STAT, 16'h001f);
        wr(FAS_ADDR_IRQ_MASK, 16'h0001);
        wr(FAS_ADDR_CTRL, 16'h0100);
        fault(1);
        chk(irq, 1);
        rd(FAS_ADDR_IRQ_STAT, 16'h0001);
        wr(FAS_ADDR_IRQ_MASK, 16'h0000);
        cyc(2);
        chk(irq, 0);
        manual(0);
        wr(FAS_ADDR_IRQ_MASK, 16'h0001);
        wr(FAS_ADDR_IRQ_STAT, 16'h001f);
        cyc(2);
        chk(irq, 0);
        rd(FAS_ADDR_IRQ_STAT, 16'h0000);
        test_done();
    end
endmodule : tb
